// ---- src/fplsu_pkg.sv ----
package fplsu_pkg;

  // Register regions: byte address bits [7:6]
  localparam logic [1:0] RGN_CTRL = 2'h0;
  localparam logic [1:0] RGN_GPR = 2'h1;
  localparam logic [1:0] RGN_FRONT = 2'h2;
  localparam logic [1:0] RGN_EXT = 2'h3;

  // Word index inside the control region: byte address bits [5:2]
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_INSN = 4'h1;
  localparam logic [3:0] IDX_STAT = 4'h2;
  localparam logic [3:0] IDX_IRQ_STAT = 4'h3;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h4;

  // Control register fields
  localparam int CTRL_W = 4;
  localparam int PREC_BIT = 0;
  localparam int SIZE_BIT = 1;
  localparam int FPU_OFF_BIT = 2;
  localparam int SLOT_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_EXC_LSB = 4;

  // Interrupt status / mask fields
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // Encodings
  localparam logic [3:0] OP_TOP = 4'hF;
  localparam logic [3:0] LO_ZDISP = 4'h8;
  localparam logic [3:0] LO_POSTINC = 4'h9;
  localparam logic [3:0] LO_INDEX = 4'h6;
  localparam logic [4:0] LO5_STORE_PAIR = 5'h17;
  localparam logic [3:0] INDEX_REG = 4'h0;

  // Address steps
  localparam logic [31:0] STEP_SINGLE = 32'h4;
  localparam logic [31:0] STEP_PAIR = 32'h8;

  typedef enum logic [3:0] {
    EXC_NONE = 4'h0,
    EXC_SLOT_FPU_OFF = 4'h1,
    EXC_FPU_OFF = 4'h2,
    EXC_ILLEGAL = 4'h3,
    EXC_RD_ADDR = 4'h4,
    EXC_RD_TLB = 4'h5,
    EXC_RD_PROT = 4'h6,
    EXC_WR_ADDR = 4'h7,
    EXC_WR_TLB = 4'h8,
    EXC_WR_PROT = 4'h9,
    EXC_FIRST_WRITE = 4'hA
  } fplsu_exc_e;

  typedef enum logic [2:0] {
    FLT_NONE = 3'h0,
    FLT_ADDR = 3'h1,
    FLT_TLB = 3'h2,
    FLT_PROT = 3'h3,
    FLT_FIRST_WRITE = 3'h4
  } fplsu_flt_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WORD0 = 2'b01,
    ST_WORD1 = 2'b10
  } fplsu_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fplsu_mreq_s;

  typedef struct packed {
    logic ack;
    fplsu_flt_e flt;
    logic [31:0] rdata;
  } fplsu_mrsp_s;

  typedef struct packed {
    logic valid;
    logic store;
    logic pair;
    logic ext;
    logic postinc;
    logic indexed;
    logic [3:0] dst;
    logic [3:0] base;
  } fplsu_dec_s;

endpackage : fplsu_pkg

// ---- src/fplsu_core.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module fplsu_core #(
  parameter int WB_AW = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output fplsu_pkg::fplsu_mreq_s mem_req_o,
  input fplsu_pkg::fplsu_mrsp_s mem_rsp_i
);
  import fplsu_pkg::*;

  if (WB_AW < 8) begin : g_aw_chk
    $error("WB_AW must be at least 8");
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : lane_merge
  function automatic logic [31:0] eff_addr(input logic [31:0] b,
                                           input logic [31:0] x,
                                           input logic use_x);
    return b + (use_x ? x : 32'h0);
  endfunction : eff_addr
  function automatic fplsu_dec_s decode(input logic [15:0] op,
                                        input logic prec,
                                        input logic size);
    fplsu_dec_s d;
    d = '0;
    if (op[15:12] == OP_TOP) begin
      if (op[4:0] == LO5_STORE_PAIR) begin
        d.valid = size & ~prec;
        d.store = 1'b1;
        d.pair = 1'b1;
        d.ext = 1'b1;
        d.indexed = 1'b1;
        d.dst = {op[7:5], 1'b0};
        d.base = op[11:8];
      end else if (op[3:0] == LO_ZDISP || op[3:0] == LO_POSTINC ||
                   op[3:0] == LO_INDEX) begin
        d.base = op[7:4];
        d.postinc = (op[3:0] == LO_POSTINC);
        d.indexed = (op[3:0] == LO_INDEX);
        if (!size) begin
          // 32-bit transfer, any precision
          d.valid = 1'b1;
          d.dst = op[11:8];
        end else begin
          d.valid = ~prec;
          d.pair = 1'b1;
          d.ext = op[8];
          d.dst = {op[11:9], 1'b0};
        end
      end
    end
    return d;
  endfunction : decode
  function automatic fplsu_exc_e fault_to_exc(input fplsu_flt_e f,
                                              input logic st);
    case (f)
      FLT_ADDR: return st ? EXC_WR_ADDR : EXC_RD_ADDR;
      FLT_TLB: return st ? EXC_WR_TLB : EXC_RD_TLB;
      FLT_PROT: return st ? EXC_WR_PROT : EXC_RD_PROT;
      FLT_FIRST_WRITE: return EXC_FIRST_WRITE;
      default: return EXC_NONE;
    endcase
  endfunction : fault_to_exc
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] gpr_ff [16];
  logic [31:0] front_ff [16];
  logic [31:0] ext_ff [16];
  logic [CTRL_W-1:0] ctrl_ff;
  logic [15:0] insn_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic irq_ff;
  fplsu_state_e state_ff;
  fplsu_dec_s cur_ff;
  fplsu_exc_e exc_ff;
  fplsu_mreq_s mreq_ff;
  logic [31:0] base_ff;
  logic [31:0] word0_ff;
  logic ev_done_ff;
  logic ev_fault_ff;
  // Bus decode; writes land on the edge where the master sees ack
  logic [1:0] rgn;
  logic [3:0] widx;
  logic wb_wr;
  logic ctl_wr;
  logic [31:0] insn_w32;
  logic [15:0] insn_w;
  logic issue;
  fplsu_dec_s dec;
  logic fpu_off;
  logic rsp_ok;
  logic rsp_bad;
  logic commit;
  logic ld_commit;
  logic [31:0] base_peek;
  logic [31:0] idx_peek;
  logic [31:0] next_rdat;
  assign rgn = wb_adr_i[7:6];
  assign widx = wb_adr_i[5:2];
  assign wb_wr = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i;
  assign ctl_wr = wb_wr && (rgn == RGN_CTRL);
  assign insn_w32 = lane_merge({16'h0, insn_ff}, wb_dat_i, wb_sel_i);
  assign insn_w = insn_w32[15:0];
  // Writes to the opcode while busy are dropped
  assign issue = ctl_wr && (widx == IDX_INSN) && (state_ff == ST_IDLE);
  assign dec = decode(insn_w, ctrl_ff[PREC_BIT], ctrl_ff[SIZE_BIT]);
  assign fpu_off = ctrl_ff[FPU_OFF_BIT];
  assign base_peek = gpr_ff[dec.base];
  assign idx_peek = gpr_ff[INDEX_REG];
  assign rsp_ok = mem_rsp_i.ack && mreq_ff.req &&
                  (mem_rsp_i.flt == FLT_NONE);
  assign rsp_bad = mem_rsp_i.ack && mreq_ff.req &&
                   (mem_rsp_i.flt != FLT_NONE);
  assign commit = rsp_ok && ((state_ff == ST_WORD1) ||
                  (state_ff == ST_WORD0 && !cur_ff.pair));
  assign ld_commit = commit && !cur_ff.store;
  ////////////////////////////////////////////////////////////////////////////
  // Execution engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cur_ff <= '0;
      exc_ff <= EXC_NONE;
      mreq_ff <= '0;
      base_ff <= 32'h0;
      word0_ff <= 32'h0;
      ev_done_ff <= 1'b0;
      ev_fault_ff <= 1'b0;
    end else begin
      ev_done_ff <= 1'b0;
      ev_fault_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (issue) begin
            if (fpu_off) begin
              exc_ff <= ctrl_ff[SLOT_BIT] ? EXC_SLOT_FPU_OFF
                                          : EXC_FPU_OFF;
              ev_fault_ff <= 1'b1;
            end else if (!dec.valid) begin
              exc_ff <= EXC_ILLEGAL;
              ev_fault_ff <= 1'b1;
            end else begin
              cur_ff <= dec;
              exc_ff <= EXC_NONE;
              base_ff <= base_peek;
              mreq_ff.req <= 1'b1;
              mreq_ff.we <= dec.store;
              mreq_ff.addr <= eff_addr(base_peek, idx_peek,
                                       dec.indexed);
              mreq_ff.wdata <= ext_ff[dec.dst];
              state_ff <= ST_WORD0;
            end
          end
        end
        ST_WORD0, ST_WORD1: begin
          if (rsp_bad) begin
            // No register is written on a fault; a pair store's first word is already in memory
            mreq_ff.req <= 1'b0;
            exc_ff <= fault_to_exc(mem_rsp_i.flt,
                                   cur_ff.store);
            ev_fault_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end else if (rsp_ok && state_ff == ST_WORD0 && cur_ff.pair) begin
            word0_ff <= mem_rsp_i.rdata;
            mreq_ff.addr <= mreq_ff.addr + STEP_SINGLE;
            mreq_ff.wdata <= ext_ff[{cur_ff.dst[3:1], 1'b1}];
            state_ff <= ST_WORD1;
          end else if (commit) begin
            mreq_ff.req <= 1'b0;
            ev_done_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          mreq_ff <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Integer base registers; post-increment wins over a bus write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        gpr_ff[i] <= 32'h0;
      end
    end else if (ld_commit && cur_ff.postinc) begin
      gpr_ff[cur_ff.base] <= base_ff +
                             (cur_ff.pair ? STEP_PAIR : STEP_SINGLE);
    end else if (wb_wr && rgn == RGN_GPR) begin
      gpr_ff[widx] <= lane_merge(gpr_ff[widx], wb_dat_i, wb_sel_i);
    end
  end

  // Front bank: single loads and front pairs, stored untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        front_ff[i] <= 32'h0;
      end
    end else if (ld_commit && !cur_ff.ext) begin
      if (cur_ff.pair) begin
        front_ff[cur_ff.dst] <= word0_ff;
        front_ff[{cur_ff.dst[3:1], 1'b1}] <= mem_rsp_i.rdata;
      end else begin
        front_ff[cur_ff.dst] <= mem_rsp_i.rdata;
      end
    end else if (wb_wr && rgn == RGN_FRONT) begin
      front_ff[widx] <= lane_merge(front_ff[widx], wb_dat_i, wb_sel_i);
    end
  end

  // Extended bank
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        ext_ff[i] <= 32'h0;
      end
    end else if (ld_commit && cur_ff.ext) begin
      ext_ff[cur_ff.dst] <= word0_ff;
      ext_ff[{cur_ff.dst[3:1], 1'b1}] <= mem_rsp_i.rdata;
    end else if (wb_wr && rgn == RGN_EXT) begin
      ext_ff[widx] <= lane_merge(ext_ff[widx], wb_dat_i, wb_sel_i);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST;
      insn_ff <= 16'h0;
      irq_mask_ff <= IRQ_RST;
    end else begin
      if (ctl_wr && widx == IDX_CTRL) begin
        ctrl_ff <= wb_sel_i[0] ? wb_dat_i[CTRL_W-1:0] : ctrl_ff;
      end
      if (issue) begin
        insn_ff <= insn_w;
      end
      if (ctl_wr && widx == IDX_IRQ_MASK) begin
        irq_mask_ff <= wb_sel_i[0] ? wb_dat_i[IRQ_W-1:0] : irq_mask_ff;
      end
    end
  end

  // Sticky events; a new event beats a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= IRQ_RST;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff &
                      ~((ctl_wr && widx == IDX_IRQ_STAT && wb_sel_i[0]) ?
                        wb_dat_i[IRQ_W-1:0] : IRQ_RST)) |
                     {ev_fault_ff, ev_done_ff};
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: ack one cycle after the strobe, unmapped reads give zero
  always_comb begin
    next_rdat = 32'h0;
    case (rgn)
      RGN_GPR: next_rdat = gpr_ff[widx];
      RGN_FRONT: next_rdat = front_ff[widx];
      RGN_EXT: next_rdat = ext_ff[widx];
      default: begin
        case (widx)
          IDX_CTRL: next_rdat[CTRL_W-1:0] = ctrl_ff;
          IDX_INSN: next_rdat[15:0] = insn_ff;
          IDX_STAT: begin
            next_rdat[STAT_BUSY_BIT] = (state_ff != ST_IDLE);
            next_rdat[STAT_EXC_LSB +: 4] = exc_ff;
          end
          IDX_IRQ_STAT: next_rdat[IRQ_W-1:0] = irq_stat_ff;
          IDX_IRQ_MASK: next_rdat[IRQ_W-1:0] = irq_mask_ff;
          default: next_rdat = 32'h0;
        endcase
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
      if (wb_cyc_i & wb_stb_i & ~ack_ff) begin
        rdat_ff <= next_rdat;
      end
    end
  end

  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_ff;
  assign irq_o = irq_ff;
  assign mem_req_o = mreq_ff;
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [31:0] cur_base_now;
  assign cur_base_now = gpr_ff[cur_ff.base];
  slot_fault_a: assert property (
    issue && fpu_off && ctrl_ff[SLOT_BIT]
    |=> exc_ff == EXC_SLOT_FPU_OFF && !mem_req_o.req)
    else $error("slot fpu-off fault missing");
  plain_fault_a: assert property (
    issue && fpu_off && !ctrl_ff[SLOT_BIT]
    |=> exc_ff == EXC_FPU_OFF ##1 irq_stat_ff[IRQ_FAULT_BIT])
    else $error("fpu-off fault missing");
  pair_mode_a: assert property (
    issue && !fpu_off && ctrl_ff[PREC_BIT] && ctrl_ff[SIZE_BIT] &&
    insn_w[15:12] == OP_TOP && insn_w[3:0] == LO_ZDISP
    |=> exc_ff == EXC_ILLEGAL && state_ff == ST_IDLE)
    else $error("pair accepted with precision set");
  single_addr_a: assert property (
    issue && !fpu_off && !ctrl_ff[SIZE_BIT] &&
    insn_w[15:12] == OP_TOP && insn_w[3:0] == LO_ZDISP
    |=> mem_req_o.req && !mem_req_o.we &&
        mem_req_o.addr == $past(base_peek))
    else $error("single load address wrong");
  index_addr_a: assert property (
    issue && !fpu_off && dec.valid && dec.indexed
    |=> mem_req_o.addr == 32'($past(base_peek) + $past(idx_peek)))
    else $error("indexed address wrong");
  second_word_a: assert property (
    state_ff == ST_WORD0 && rsp_ok && cur_ff.pair
    |=> mem_req_o.req &&
        mem_req_o.addr == 32'($past(mem_req_o.addr) + STEP_SINGLE))
    else $error("second word address wrong");
  post_inc_a: assert property (
    ld_commit && cur_ff.postinc
    |=> cur_base_now == 32'($past(base_ff) +
                            ($past(cur_ff.pair) ? STEP_PAIR : STEP_SINGLE)))
    else $error("base writeback wrong");
  fault_hold_a: assert property (
    rsp_bad && !(wb_wr && rgn == RGN_GPR)
    |=> $stable(cur_base_now) && state_ff == ST_IDLE)
    else $error("state changed on fault");
  read_fault_a: assert property (
    rsp_bad && !cur_ff.store && mem_rsp_i.flt == FLT_TLB
    |=> exc_ff == EXC_RD_TLB)
    else $error("read miss not raised");
  write_fault_a: assert property (
    rsp_bad && cur_ff.store && mem_rsp_i.flt == FLT_PROT
    |=> exc_ff == EXC_WR_PROT)
    else $error("write protection not raised");
  pair_store_c: cover property (commit && cur_ff.store);
  ext_load_c: cover property (ld_commit && cur_ff.ext && cur_ff.postinc);
  fault_c: cover property (rsp_bad && state_ff == ST_WORD1);
  irq_c: cover property (irq_o);
endmodule : fplsu_core

// ---- tb/fplsu_mem_model.sv ----
`timescale 1ns/1ps
module fplsu_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] delay_i,
  input wire logic [2:0] flt_i,
  input wire logic [31:0] flt_addr_i,
  input fplsu_pkg::fplsu_mreq_s mem_req_i,
  output fplsu_pkg::fplsu_mrsp_s mem_rsp_o
);
  import fplsu_pkg::*;
  logic [31:0] mem [0:63];
  logic [3:0] wait_ff;
  logic ack_ff;
  logic [2:0] flt_ff;
  logic [31:0] data_ff;
  logic hit;
  logic bad;

  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'h7FA00000 + 32'(i);
    end
  end

  assign hit = mem_req_i.req && !ack_ff && wait_ff == delay_i;
  assign bad = mem_req_i.addr == flt_addr_i && flt_i != 3'h0;
  ////////////////////////////////////////////////////////////////////////////
  // Wait counter: slow answers stretch the request
  always_ff @(posedge clk_i) begin
    if (rst_i || !mem_req_i.req || ack_ff) begin
      wait_ff <= 4'h0;
    end else if (!hit) begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Answer; idle data toggles so stale words never look valid
  always @(posedge clk_i) begin
    ack_ff <= !rst_i && hit;
    if (hit) begin
      flt_ff <= bad ? flt_i : 3'h0;
      if (!mem_req_i.we) begin
        data_ff <= mem[mem_req_i.addr[7:2]];
      end else if (!bad) begin
        mem[mem_req_i.addr[7:2]] <= mem_req_i.wdata;
      end
    end else begin
      data_ff <= ~data_ff;
    end
  end

  assign mem_rsp_o.ack = ack_ff;
  assign mem_rsp_o.flt = ack_ff ? fplsu_flt_e'(flt_ff) : fplsu_flt_e'(3'h7);
  assign mem_rsp_o.rdata = data_ff;
endmodule : fplsu_mem_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import fplsu_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic irq;
  fplsu_mreq_s mem_req;
  fplsu_mrsp_s mem_rsp;
  logic [3:0] delay = 4'h0;
  logic [2:0] flt = 3'h0;
  logic [31:0] flt_addr = 32'h0;
  logic [31:0] addr_q [$];
  logic [31:0] rd;
  int n_mismatch = 0;
  int total_checks = 0;
  fplsu_exc_e rx [3] = '{EXC_RD_ADDR, EXC_RD_TLB, EXC_RD_PROT};
  fplsu_exc_e wx [4] = '{EXC_WR_ADDR, EXC_WR_TLB, EXC_WR_PROT,
                         EXC_FIRST_WRITE};

  always #50 clk_i = ~clk_i;

  fplsu_core uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq),
    .mem_req_o(mem_req), .mem_rsp_i(mem_rsp)
  );

  fplsu_mem_model mem_m (
    .clk_i(clk_i), .rst_i(rst_i), .delay_i(delay), .flt_i(flt),
    .flt_addr_i(flt_addr), .mem_req_i(mem_req), .mem_rsp_o(mem_rsp)
  );

  always @(posedge clk_i) begin
    if (mem_req.req && mem_rsp.ack) addr_q.push_back(mem_req.addr);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] pat(input int i);
    return 32'h7FA00000 + 32'(i);
  endfunction : pat

  // Classic cycle; a hung slave ends the run instead of the wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
  endtask : wb

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rdchk

  task automatic irqchk(input logic exp);
    repeat (2) @(posedge clk_i);
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask : irqchk

  task automatic run(input logic [3:0] ctrl, input logic [15:0] insn,
                     input fplsu_exc_e exc);
    int n;
    n = 0;
    wb(1'b1, 8'h00, {28'h0, ctrl});
    addr_q.delete();
    wb(1'b1, 8'h04, {16'h0, insn});
    do begin
      wb(1'b0, 8'h08, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    if (rd[0] !== 1'b0) begin
      n_mismatch++;
      complete_run();
    end
    check("exc", {28'h0, rd[7:4]}, {28'h0, exc});
  endtask : run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("ctrl", 8'h00, 32'h0);
    rdchk("mask", 8'h10, 32'h0);
    irqchk(1'b0);
    wb(1'b1, 8'h14, 32'hFFFFFFFF);
    rdchk("unmapped", 8'h14, 32'h0);
    wb(1'b1, 8'h40, 32'h10);
    wb(1'b1, 8'h48, 32'h20);
    wb(1'b1, 8'h4C, 32'hFFFFFFFC);
    wb(1'b1, 8'h50, 32'h30);
    $display("test reset and map done");
    delay <= 4'h2;
    run(4'h1, 16'hF528, EXC_NONE);
    rdchk("fr5", 8'h94, pat(8));
    run(4'h0, 16'hF629, EXC_NONE);
    rdchk("fr6", 8'h98, pat(8));
    rdchk("r2", 8'h48, 32'h24);
    run(4'h0, 16'hF736, EXC_NONE);
    check("ea", addr_q[0], 32'h0000000C);
    check("nreq", 32'(addr_q.size()), 32'h1);
    rdchk("fr7", 8'h9C, pat(3));
    run(4'h2, 16'hF428, EXC_NONE);
    check("ea1", addr_q[1], 32'h28);
    check("nreq", 32'(addr_q.size()), 32'h2);
    rdchk("fr4", 8'h90, pat(9));
    rdchk("fr5", 8'h94, pat(10));
    delay <= 4'h0;
    run(4'h2, 16'hF329, EXC_NONE);
    rdchk("xd2", 8'hC8, pat(9));
    rdchk("xd3", 8'hCC, pat(10));
    rdchk("r2", 8'h48, 32'h2C);
    run(4'h2, 16'hF736, EXC_NONE);
    check("ea1", addr_q[1], 32'h10);
    rdchk("xd7", 8'hDC, pat(4));
    run(4'h2, 16'hF437, EXC_NONE);
    check("st0", mem_m.mem[16], pat(9));
    check("st1", mem_m.mem[17], pat(10));
    $display("test transfers done");
    run(4'h3, 16'hF428, EXC_ILLEGAL);
    check("nreq", 32'(addr_q.size()), 32'h0);
    run(4'h6, 16'hF528, EXC_FPU_OFF);
    run(4'hE, 16'hF528, EXC_SLOT_FPU_OFF);
    check("nreq", 32'(addr_q.size()), 32'h0);
    rdchk("fr4", 8'h90, pat(9));
    $display("test refusals done");
    wb(1'b1, 8'h0C, 32'h3);
    run(4'h2, 16'hF428, EXC_NONE);
    rdchk("istat", 8'h0C, 32'h1);
    irqchk(1'b0);
    wb(1'b1, 8'h10, 32'h1);
    irqchk(1'b1);
    wb(1'b1, 8'h0C, 32'h1);
    irqchk(1'b0);
    wb(1'b1, 8'h10, 32'h2);
    $display("test interrupts done");
    delay <= 4'h1;
    flt_addr <= 32'h30;
    for (int i = 1; i <= 3; i++) begin
      flt <= 3'(i);
      run(4'h2, 16'hF329, rx[i-1]);
      rdchk("r2", 8'h48, 32'h2C);
      rdchk("xd2", 8'hC8, pat(9));
    end
    irqchk(1'b1);
    rdchk("istat", 8'h0C, 32'h2);
    flt_addr <= 32'h40;
    for (int i = 1; i <= 4; i++) begin
      flt <= 3'(i);
      run(4'h2, 16'hF437, wx[i-1]);
    end
    $display("test faults done");
    complete_run();
  end
endmodule : tb_top
